// ---- rtl/dosr_status_reg.sv ----
// Diagnostic status register of a dual-section output supply controller.
// Assumes detector inputs are asynchronous levels and the serial interface
// front end delivers decoded single-cycle read and write strobes.
//
// Operation
// - Status register is read only; writes ignored
// - Status register one sits at address zero
// - Bits 0/1 show section overload trip
// - Bits 2/3 show section output undervoltage
// - Bits 4/5 show persistent pull-down overcurrent
// - Bit 6 sets above about 150 C
// - Bit 6 clears only below about 135 C
// - Bit 7 shows input supply below threshold
// - All status bits zero at power-on
`timescale 1ns/1ps
`include "dosr_consts.svh"

module dosr_status_reg import dosr_pkg::*; #(
  parameter int DEGLITCH_CYCLES = `DOSR_DEGLITCH_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,

  // Section A detectors
  input wire logic overload_trip_a_i,
  input wire logic undervoltage_a_i,
  input wire logic pulldown_oc_a_i,

  // Section B detectors
  input wire logic overload_trip_b_i,
  input wire logic undervoltage_b_i,
  input wire logic pulldown_oc_b_i,

  // Shared detectors
  input wire logic temp_above_set_i,
  input wire logic temp_below_clear_i,
  input wire logic low_supply_detect_i,

  // Register port from the serial interface
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [`DOSR_ADDR_W-1:0] reg_addr_i,
  input wire logic [`DOSR_DATA_W-1:0] reg_wdata_i,
  output logic [`DOSR_DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_wr_refused_o,

  // Live flags for the protection logic
  output logic [`DOSR_DATA_W-1:0] status_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Local types

  localparam int CNT_W = $clog2(DEGLITCH_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(DEGLITCH_CYCLES);

  typedef struct packed {
    dosr_status_type status;
    logic [1:0][CNT_W-1:0] pd_cnt;
    logic [`DOSR_DATA_W-1:0] rdata;
    logic rvalid;
    logic wr_refused;
  } dosr_state_type;

  // Power-on value: every flag clear, no answer pending
  localparam dosr_state_type STATE_RESET = '{
    status: dosr_status_type'(`DOSR_STATUS_ONE_RESET),
    pd_cnt: '0,
    rdata: `DOSR_STATUS_ONE_RESET,
    rvalid: 1'b0,
    wr_refused: 1'b0
  };

  dosr_state_type state_q;
  dosr_state_type state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisation of detector lines

  dosr_detect_type det_raw;
  dosr_detect_type det;
  logic [$bits(dosr_detect_type)-1:0] det_sync;

  always_comb begin
    det_raw.supply_low = low_supply_detect_i;
    det_raw.temp_below_clear = temp_below_clear_i;
    det_raw.temp_above_set = temp_above_set_i;
    det_raw.pulldown_oc = {pulldown_oc_b_i, pulldown_oc_a_i};
    det_raw.undervoltage = {undervoltage_b_i, undervoltage_a_i};
    det_raw.overload = {overload_trip_b_i, overload_trip_a_i};
  end

  dosr_sync #(
    .WIDTH($bits(dosr_detect_type))
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(det_raw),
    .sync_o(det_sync)
  );

  assign det = dosr_detect_type'(det_sync);

  // Unused: the register cannot be written
  logic wdata_unused;
  assign wdata_unused = ^reg_wdata_i;

  ////////////////////////////////////////////////////////////////////////////
  // Pull-down overcurrent deglitch

  // A counter runs while its overcurrent line stays high and saturates;
  // any low cycle restarts it, so short pulses never raise the flag
  logic [1:0][CNT_W-1:0] pd_cnt_next;
  logic [1:0] pd_flag;

  always_comb begin
    pd_cnt_next = state_q.pd_cnt;
    pd_flag = 2'h0;
    for (int s = 0; s < 2; s++) begin
      if (!det.pulldown_oc[s]) begin
        pd_cnt_next[s] = '0;
      end else if (state_q.pd_cnt[s] != CNT_MAX) begin
        pd_cnt_next[s] = state_q.pd_cnt[s] + CNT_W'(1);
      end
      pd_flag[s] = det.pulldown_oc[s] && (state_q.pd_cnt[s] == CNT_MAX);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overtemperature hysteresis

  // Between the two thresholds neither comparator is active and the flag
  // holds; the set comparator wins if both are seen together
  logic ot_next;

  always_comb begin
    ot_next = state_q.status.overtemperature_flag;
    if (det.temp_above_set) begin
      ot_next = 1'b1;
    end else if (det.temp_below_clear) begin
      ot_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register map

  // Bits are placed by their field positions, so the read word does not
  // depend on the member order of the status struct
  logic [`DOSR_DATA_W-1:0] status_vec;
  logic addr_hit;
  logic [`DOSR_DATA_W-1:0] rd_word;

  always_comb begin
    status_vec = '0;
    status_vec[`DOSR_BIT_OVERLOAD_A] = state_q.status.overload_flag_sec_a;
    status_vec[`DOSR_BIT_OVERLOAD_B] = state_q.status.overload_flag_sec_b;
    status_vec[`DOSR_BIT_UNDERVOLT_A] = state_q.status.undervoltage_flag_sec_a;
    status_vec[`DOSR_BIT_UNDERVOLT_B] = state_q.status.undervoltage_flag_sec_b;
    status_vec[`DOSR_BIT_PULLDOWN_A] = state_q.status.pulldown_overcurrent_sec_a;
    status_vec[`DOSR_BIT_PULLDOWN_B] = state_q.status.pulldown_overcurrent_sec_b;
    status_vec[`DOSR_BIT_OVERTEMP] = state_q.status.overtemperature_flag;
    status_vec[`DOSR_BIT_SUPPLY_LOW] = state_q.status.supply_low_flag;
    addr_hit = (reg_addr_i == `DOSR_STATUS_ONE_ADDR);
    rd_word = `DOSR_UNMAPPED_DATA;
    if (addr_hit) begin
      rd_word = status_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_d = state_q;

    // Overload trip follows the protection comparator
    state_d.status.overload_flag_sec_a = det.overload[0];
    state_d.status.overload_flag_sec_b = det.overload[1];

    // Undervoltage follows the monitor, clearing once back in range
    state_d.status.undervoltage_flag_sec_a = det.undervoltage[0];
    state_d.status.undervoltage_flag_sec_b = det.undervoltage[1];

    // Pull-down overcurrent only once it outlasts the deglitch time
    state_d.pd_cnt = pd_cnt_next;
    state_d.status.pulldown_overcurrent_sec_a = pd_flag[0];
    state_d.status.pulldown_overcurrent_sec_b = pd_flag[1];

    // Overtemperature with hysteresis
    state_d.status.overtemperature_flag = ot_next;

    // Input supply low
    state_d.status.supply_low_flag = det.supply_low;

    // Read returns live flags and leaves them untouched
    state_d.rvalid = reg_rd_i;
    if (reg_rd_i) begin
      state_d.rdata = rd_word;
    end

    // Writes are refused and change nothing
    state_d.wr_refused = reg_wr_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_o = state_q.rdata;
  assign reg_rvalid_o = state_q.rvalid;
  assign reg_wr_refused_o = state_q.wr_refused;
  assign status_o = status_vec;

endmodule // dosr_status_reg

// ---- shared/dosr_consts.svh ----
// Constants of the dual-section diagnostic status register.
// Assumes the logic clock runs at 100 MHz.
`ifndef DOSR_CONSTS_SVH
`define DOSR_CONSTS_SVH

// Register map
`define DOSR_ADDR_W 8
`define DOSR_DATA_W 8
`define DOSR_STATUS_ONE_ADDR 8'h00
`define DOSR_STATUS_ONE_RESET 8'h00
`define DOSR_UNMAPPED_DATA 8'h00

// Field positions of diagnostic_status_one
`define DOSR_BIT_OVERLOAD_A 0
`define DOSR_BIT_OVERLOAD_B 1
`define DOSR_BIT_UNDERVOLT_A 2
`define DOSR_BIT_UNDERVOLT_B 3
`define DOSR_BIT_PULLDOWN_A 4
`define DOSR_BIT_PULLDOWN_B 5
`define DOSR_BIT_OVERTEMP 6
`define DOSR_BIT_SUPPLY_LOW 7

// Timing
`define DOSR_CLK_PERIOD_NS 10
`define DOSR_DEGLITCH_NS 2000
`define DOSR_DEGLITCH_CYCLES ((`DOSR_DEGLITCH_NS + `DOSR_CLK_PERIOD_NS - 1) / `DOSR_CLK_PERIOD_NS)

// Synchroniser depth
`define DOSR_SYNC_STAGES 2

`endif

// ---- shared/dosr_pkg.sv ----
// Types of the dual-section diagnostic status register.
// Assumes dosr_consts.svh is on the include path.
`include "dosr_consts.svh"

package dosr_pkg;

  // Layout of diagnostic_status_one, bit 7 first
  typedef struct packed {
    logic supply_low_flag;
    logic overtemperature_flag;
    logic pulldown_overcurrent_sec_b;
    logic pulldown_overcurrent_sec_a;
    logic undervoltage_flag_sec_b;
    logic undervoltage_flag_sec_a;
    logic overload_flag_sec_b;
    logic overload_flag_sec_a;
  } dosr_status_type;

  // Detector lines after synchronisation
  typedef struct packed {
    logic supply_low;
    logic temp_below_clear;
    logic temp_above_set;
    logic [1:0] pulldown_oc;
    logic [1:0] undervoltage;
    logic [1:0] overload;
  } dosr_detect_type;

endpackage

// ---- rtl/dosr_sync.sv ----
// Two-flop synchroniser for a group of independent level signals.
// Assumes each bit is a slow level; no bus coherency across bits.
`timescale 1ns/1ps

module dosr_sync import dosr_pkg::*; #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } dosr_sync_state_type;

  dosr_sync_state_type state_q;
  dosr_sync_state_type state_d;

  always_comb begin
    state_d = state_q;
    state_d.meta = async_i;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_o = state_q.stable;

endmodule // dosr_sync

// ---- bench/dosr_status_reg_asserts.sv ----
// Port assertions for the diagnostic status register.
// Assumes binding to dosr_status_reg; detectors pass two sync flops.
`timescale 1ns/1ps
module dosr_status_reg_asserts (
  input logic clk_i,
  input logic rst_i,
  input logic overload_trip_a_i,
  input logic overload_trip_b_i,
  input logic pulldown_oc_a_i,
  input logic temp_above_set_i,
  input logic temp_below_clear_i,
  input logic low_supply_detect_i,
  input logic reg_rd_i,
  input logic reg_wr_i,
  input logic [7:0] reg_addr_i,
  input logic [7:0] reg_rdata_o,
  input logic reg_rvalid_o,
  input logic reg_wr_refused_o,
  input logic [7:0] status_o
);
  // Counts edges since reset so $past never reaches into reset
  logic [1:0] up_q;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rd_ans; reg_rd_i |=> reg_rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  property p_rd_data; reg_rd_i && reg_addr_i == 8'h00 ##1 $stable(status_o) |-> reg_rdata_o == status_o; endproperty
  a_rd_data: assert property (p_rd_data) else $error("bad read data");
  property p_unmap; reg_rd_i && reg_addr_i != 8'h00 |=> reg_rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  property p_wr; reg_wr_i |=> reg_wr_refused_o; endproperty
  a_wr: assert property (p_wr) else $error("write not refused");
  property p_rv_pulse; !reg_rd_i |=> !reg_rvalid_o; endproperty
  a_rv_pulse: assert property (p_rv_pulse) else $error("read answer too long");
  property p_wr_pulse; !reg_wr_i |=> !reg_wr_refused_o; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("refusal too long");
  property p_ovl; up_q == 2'h3 |-> status_o[1:0] == $past({overload_trip_b_i, overload_trip_a_i}, 3); endproperty
  a_ovl: assert property (p_ovl) else $error("overload bits");
  property p_pd; up_q == 2'h3 && !$past(pulldown_oc_a_i, 3) |-> !status_o[4]; endproperty
  a_pd: assert property (p_pd) else $error("pull-down bit");
  property p_ot_set; temp_above_set_i |-> ##3 status_o[6]; endproperty
  a_ot_set: assert property (p_ot_set) else $error("overtemp set");
  property p_ot_clr; $fell(status_o[6]) |-> $past(temp_below_clear_i, 3) && !$past(temp_above_set_i, 3); endproperty
  a_ot_clr: assert property (p_ot_clr) else $error("overtemp clear");
  property p_sup; up_q == 2'h3 |-> status_o[7] == $past(low_supply_detect_i, 3); endproperty
  a_sup: assert property (p_sup) else $error("supply bit");
endmodule // dosr_status_reg_asserts

bind dosr_status_reg dosr_status_reg_asserts i_chk (.*);

// ---- bench/dosr_host_model.sv ----
// Bus master stand-in issuing single-cycle read and write strobes.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/1ps
module dosr_host_model (
  // Clock and answers
  input logic clk_i,
  input logic reg_rvalid_i,
  input logic reg_wr_refused_i,
  input logic [7:0] reg_rdata_i,
  // Requests
  output logic reg_rd_o = 1'b0,
  output logic reg_wr_o = 1'b0,
  output logic [7:0] reg_addr_o = 8'h00,
  output logic [7:0] reg_wdata_o = 8'h00
);
  task automatic rd(input logic [7:0] a, output logic v, output logic [7:0] d);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge clk_i);
    v = reg_rvalid_i;
    d = reg_rdata_i;
  endtask
  // Only used to show that writes are refused
  task automatic wr(input logic [7:0] a, input logic [7:0] w, output logic v);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= w;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~w;
    @(posedge clk_i);
    v = reg_wr_refused_i;
  endtask
endmodule // dosr_host_model

// ---- bench/dosr_status_reg_test.sv ----
// Self-checking testbench for the diagnostic status register.
// Assumes the host model in dosr_host_model.sv; deglitch shortened to 4.
`timescale 1ns/1ps
module dosr_status_reg_test;
  localparam int DGL = 4;
  logic clk_i = 0, rst_i = 1, overload_trip_a_i = 0, overload_trip_b_i = 0, undervoltage_a_i = 0;
  logic undervoltage_b_i = 0, pulldown_oc_a_i = 0, pulldown_oc_b_i = 0, temp_above_set_i = 0;
  logic temp_below_clear_i = 0, low_supply_detect_i = 0, reg_rd_i, reg_wr_i, reg_rvalid_o, v;
  logic reg_wr_refused_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, status_o, d;
  int fails = 0, checked = 0;
  always #5 clk_i = ~clk_i;
  dosr_status_reg #(.DEGLITCH_CYCLES(DGL)) i_dut (.*);
  dosr_host_model i_host (.clk_i, .reg_rvalid_i(reg_rvalid_o), .reg_wr_refused_i(reg_wr_refused_o),
    .reg_rdata_i(reg_rdata_o), .reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i));
  ////////////////////////////////////////////////////////////////////////////
  task set_det(input logic [8:0] x);
    {low_supply_detect_i, temp_below_clear_i, temp_above_set_i, pulldown_oc_b_i, pulldown_oc_a_i,
      undervoltage_b_i, undervoltage_a_i, overload_trip_b_i, overload_trip_a_i} <= x;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, v, d);
    chk({7'h00, v}, 8'h01);
    chk(d, e);
  endtask
  task t_levels;
    for (int i = 0; i < 9; i++) if (i < 4 || i == 8) begin
      set_det(9'h001 << i);
      repeat (4) @(posedge clk_i);
      rdc(8'h00, 8'h01 << (i == 8 ? 7 : i));
      rdc(8'h00, 8'h01 << (i == 8 ? 7 : i));
      set_det(9'h000);
      repeat (4) @(posedge clk_i);
      chk(status_o, 8'h00);
    end
  endtask
  task t_pull;
    set_det(9'h010);
    repeat (2) @(posedge clk_i);
    set_det(9'h000);
    repeat (8) @(posedge clk_i);
    chk(status_o, 8'h00);
    set_det(9'h030);
    repeat (DGL + 3) @(posedge clk_i);
    chk(status_o, 8'h00);
    @(posedge clk_i);
    chk(status_o, 8'h30);
    rdc(8'h00, 8'h30);
    set_det(9'h000);
    repeat (4) @(posedge clk_i);
  endtask
  task t_temp;
    set_det(9'h040);
    repeat (4) @(posedge clk_i);
    set_det(9'h000);
    repeat (6) @(posedge clk_i);
    rdc(8'h00, 8'h40);
    set_det(9'h080);
    repeat (4) @(posedge clk_i);
    chk(status_o, 8'h00);
  endtask
  task t_write;
    set_det(9'h001);
    repeat (4) @(posedge clk_i);
    i_host.wr(8'h00, 8'hFE, v);
    chk({7'h00, v}, 8'h01);
    rdc(8'h00, 8'h01);
    rdc(8'h05, 8'h00);
  endtask
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(8'h00, 8'h00);
    t_levels;
    t_pull;
    t_temp;
    t_write;
    report_and_stop;
  end
endmodule // dosr_status_reg_test
